// File: hw/brownout_ctrl_regs.vh
`ifndef BROWNOUT_CTRL_REGS_VH
`define BROWNOUT_CTRL_REGS_VH

// Register byte addresses.
`define OFS_GPIO_CAP        8'h1c
`define OFS_BOR_CTL         8'h30
`define OFS_LDO_CTL         8'h34
`define OFS_SRC0            8'h40
`define OFS_IRQ_STATUS      8'h50
`define OFS_IRQ_ENABLE      8'h54
`define OFS_IRQ_CLEAR       8'h58

// Capability word: five ports present.
`define GPIO_CAP_VALUE      32'h0000_001f

// Brown-out control fields and reset values.
`define BOR_TIM_HI          15
`define BOR_TIM_LO          2
`define BOR_TIM_W           14
`define BOR_SEL_BIT         1
`define BOR_WT_BIT          0
`define BOR_TIM_RST         14'h1fff
`define BOR_SEL_RST         1'b0
`define BOR_WT_RST          1'b1

// Regulator adjust field.
`define LDO_W               6
`define LDO_RST             6'h00

// Software reset bits.
`define SRC_PWM_BIT         20
`define SRC_ADC_BIT         16
`define SRC_WDT_BIT         3
`define SRC_MASK            32'h0011_0008

// Primary capability presence bits for the reset targets.
`define CAP_PWM_BIT         20
`define CAP_ADC_BIT         16
`define CAP_WDT_BIT         3

// Interrupt status layout.
`define IRQ_BOR_BIT         0
`define IRQ_W               1

// AXI response codes.
`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// File: hw/edge_sync.v
`timescale 1ns/10ps
// Two-stage synchroniser with rise detection on the settled copy only.
module edge_sync (
    input  wire aclk,
    input  wire aresetn,
    input  wire din,
    output wire level,
    output wire rise
);
    reg meta_r;
    reg sync_r;
    reg last_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~last_r;
endmodule

// File: hw/osc_tick.v
`timescale 1ns/10ps
// Turns the oscillator into a one-cycle tick on each of its rising edges.
// The oscillator must run below half the bus clock rate for every edge to be seen.
module osc_tick (
    input  wire aclk,
    input  wire aresetn,
    input  wire osc_in,
    output wire tick
);
    reg meta_r;
    reg sync_r;
    reg last_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= osc_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign tick = sync_r & ~last_r;
endmodule

// File: hw/brownout_ldo_softreset_ctrl.v
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module brownout_ldo_softreset_ctrl (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire [2:0]  s_axi_awprot,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire [2:0]  s_axi_arprot,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [31:0] primary_capabilities,
    input  wire        brownout_detector,
    input  wire        internal_oscillator,
    output reg  [5:0]  regulator_voltage_select,
    output reg         brownout_system_reset,
    output reg         pwm_soft_reset,
    output reg         adc_soft_reset,
    output reg         wdt_soft_reset,
    output wire        irq
);
`include "brownout_ctrl_regs.vh"

    localparam ST_IDLE  = 2'b00;
    localparam ST_WAIT  = 2'b01;
    localparam ST_HOLD  = 2'b10;

    // Registers.
    reg [13:0] brownout_wait_count_r;
    reg        brownout_reset_select_r;
    reg        brownout_noise_check_r;
    reg [5:0]  regulator_adjust_code_r;
    reg [31:0] src0_r;
    reg        brownout_raw_flag_r;
    reg        brownout_irq_mask_r;

    // Write channel holding latches, so address and data may arrive in any order.
    reg        aw_held_r;
    reg [7:0]  aw_addr_r;
    reg        w_held_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;

    // Brown-out sequencer.
    reg [1:0]  state_r;
    reg [1:0]  state_nxt;
    reg [13:0] wait_cnt_r;
    reg [13:0] wait_cnt_nxt;
    reg        event_nxt;

    wire       det_level;
    wire       det_rise;
    wire       osc_tick_w;
    // A zero count gives an immediate resample.
    wire       wait_done = (wait_cnt_r == 14'h0000);

    edge_sync u_det_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (brownout_detector),
        .level   (det_level),
        .rise    (det_rise)
    );

    // The oscillator is sampled as data, which avoids a second clock domain.
    osc_tick u_osc_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .osc_in  (internal_oscillator),
        .tick    (osc_tick_w)
    );

    // Byte-lane merge of a write into an old word.
    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // Unmapped offsets answer with an error rather than aliasing a register.
    function is_mapped;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_GPIO_CAP, `OFS_BOR_CTL, `OFS_LDO_CTL, `OFS_SRC0,
                `OFS_IRQ_STATUS, `OFS_IRQ_ENABLE, `OFS_IRQ_CLEAR: is_mapped = 1'b1;
                default: is_mapped = 1'b0;
            endcase
        end
    endfunction

    wire [31:0] bor_ctl_word = {16'h0000, brownout_wait_count_r,
                                brownout_reset_select_r, brownout_noise_check_r};

    // Bits of the soft reset word whose units are marked present.
    wire [31:0] src_present = ({31'h0000_0000, primary_capabilities[`CAP_PWM_BIT]}
                                   << `SRC_PWM_BIT)
                            | ({31'h0000_0000, primary_capabilities[`CAP_ADC_BIT]}
                                   << `SRC_ADC_BIT)
                            | ({31'h0000_0000, primary_capabilities[`CAP_WDT_BIT]}
                                   << `SRC_WDT_BIT);
    wire [31:0] src_wmask = src_present & `SRC_MASK;

    // A write proceeds once both halves are held and no response is outstanding.
    wire do_write = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire [31:0] wr_word_bor = merge(bor_ctl_word, w_data_r, w_strb_r);
    wire [31:0] wr_word_ldo = merge({26'h000_0000, regulator_adjust_code_r},
                                    w_data_r, w_strb_r);
    wire [31:0] wr_word_src = merge(src0_r, w_data_r, w_strb_r);
    wire [31:0] wr_word_irq = merge(32'h0000_0000, w_data_r, w_strb_r);
    wire        clr_bor     = do_write && aw_addr_r == `OFS_IRQ_CLEAR
                              && wr_word_irq[`IRQ_BOR_BIT];

    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready  = ~w_held_r;
    assign s_axi_arready = ~s_axi_rvalid;

    // Address channel holding latch.
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (s_axi_awvalid && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held_r <= 1'b0;
        end
    end

    // Data channel holding latch.
    always @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (s_axi_wvalid && !w_held_r) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (do_write) begin
            w_held_r <= 1'b0;
        end
    end

    // Write response; a new write waits until the previous answer is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes.
    always @(posedge aclk) begin
        if (!aresetn) begin
            brownout_wait_count_r   <= `BOR_TIM_RST;
            brownout_reset_select_r <= `BOR_SEL_RST;
            brownout_noise_check_r  <= `BOR_WT_RST;
            regulator_adjust_code_r <= `LDO_RST;
            src0_r                  <= 32'h0000_0000;
            brownout_irq_mask_r     <= 1'b0;
        end else if (do_write) begin
            case (aw_addr_r)
                `OFS_BOR_CTL: begin
                    brownout_wait_count_r   <= wr_word_bor[`BOR_TIM_HI:`BOR_TIM_LO];
                    brownout_reset_select_r <= wr_word_bor[`BOR_SEL_BIT];
                    brownout_noise_check_r  <= wr_word_bor[`BOR_WT_BIT];
                end
                `OFS_LDO_CTL: begin
                    regulator_adjust_code_r <= wr_word_ldo[`LDO_W-1:0];
                end
                `OFS_SRC0: begin
                    // Absent units keep their bit; a later write of 0 releases a unit only while it is marked present.
                    src0_r <= (src0_r & ~src_wmask) | (wr_word_src & src_wmask);
                end
                `OFS_IRQ_ENABLE: begin
                    brownout_irq_mask_r <= wr_word_irq[`IRQ_BOR_BIT];
                end
                default: begin
                    brownout_irq_mask_r <= brownout_irq_mask_r;
                end
            endcase
        end
    end

    // Read decode; reserved and write-only locations read as zero.
    function [31:0] read_word;
        input [7:0] addr;
        begin
            case (addr)
                `OFS_GPIO_CAP:   read_word = `GPIO_CAP_VALUE;
                `OFS_BOR_CTL:    read_word = bor_ctl_word;
                `OFS_LDO_CTL:    read_word = {26'h000_0000, regulator_adjust_code_r};
                `OFS_SRC0:       read_word = src0_r;
                `OFS_IRQ_STATUS: read_word = {31'h0000_0000, brownout_raw_flag_r};
                `OFS_IRQ_ENABLE: read_word = {31'h0000_0000, brownout_irq_mask_r};
                default:         read_word = 32'h0000_0000;
            endcase
        end
    endfunction

    // Read channel: one cycle after the address is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= is_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            s_axi_rdata  <= read_word(s_axi_araddr);
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Brown-out sequencer. The wait counts oscillator ticks, so the bus clock
    // rate does not change the filter window.
    always @* begin
        state_nxt    = state_r;
        wait_cnt_nxt = wait_cnt_r;
        event_nxt    = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (det_rise) begin
                    if (brownout_noise_check_r) begin
                        state_nxt    = ST_WAIT;
                        wait_cnt_nxt = brownout_wait_count_r;
                    end else begin
                        event_nxt = 1'b1;
                        state_nxt = ST_HOLD;
                    end
                end
            end
            ST_WAIT: begin
                if (wait_done) begin
                    if (det_level) begin
                        event_nxt = 1'b1;
                        state_nxt = ST_HOLD;
                    end else begin
                        state_nxt = ST_IDLE;
                    end
                end else if (osc_tick_w) begin
                    wait_cnt_nxt = wait_cnt_r - 14'h0001;
                end
            end
            ST_HOLD: begin
                // One report per assertion: wait for the detector to drop.
                if (!det_level) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r               <= ST_IDLE;
            wait_cnt_r            <= 14'h0000;
            brownout_system_reset <= 1'b0;
        end else begin
            state_r               <= state_nxt;
            wait_cnt_r            <= wait_cnt_nxt;
            brownout_system_reset <= event_nxt & brownout_reset_select_r;
        end
    end

    // A new event wins over a clear in the same cycle, so no brown-out is lost.
    always @(posedge aclk) begin
        if (!aresetn) begin
            brownout_raw_flag_r <= 1'b0;
        end else if (event_nxt) begin
            brownout_raw_flag_r <= 1'b1;
        end else if (clr_bor) begin
            brownout_raw_flag_r <= 1'b0;
        end
    end

    assign irq = brownout_raw_flag_r & brownout_irq_mask_r & ~brownout_reset_select_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            regulator_voltage_select <= `LDO_RST;
        end else begin
            regulator_voltage_select <= regulator_adjust_code_r;
        end
    end

    // Unit resets are registered so that a bus write never glitches a unit.
    always @(posedge aclk) begin
        if (!aresetn) begin
            pwm_soft_reset <= 1'b0;
            adc_soft_reset <= 1'b0;
            wdt_soft_reset <= 1'b0;
        end else begin
            pwm_soft_reset <= src0_r[`SRC_PWM_BIT];
            adc_soft_reset <= src0_r[`SRC_ADC_BIT];
            wdt_soft_reset <= src0_r[`SRC_WDT_BIT];
        end
    end
endmodule

// File: testbench/brownout_ctrl_monitor.sv
`timescale 1ns/10ps
`include "brownout_ctrl_regs.vh"
module brownout_ctrl_monitor (
    input logic        aclk,
    input logic        aresetn,
    input logic [7:0]  s_axi_awaddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic        s_axi_rvalid,
    input logic [31:0] primary_capabilities,
    input logic        brownout_detector,
    input logic [5:0]  regulator_voltage_select,
    input logic        brownout_system_reset,
    input logic        pwm_soft_reset,
    input logic        wdt_soft_reset,
    input logic        irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire        wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire        rd_take = s_axi_arvalid && s_axi_arready;
    wire        irq_wr  = wr_take && (s_axi_awaddr == `OFS_BOR_CTL ||
                          s_axi_awaddr == `OFS_IRQ_ENABLE || s_axi_awaddr == `OFS_IRQ_CLEAR);
    logic [5:0] ldo_exp;
    logic [2:0] irq_wr_r;
    // The interrupt may only drop within a few cycles of a write that can lower it.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ldo_exp <= `LDO_RST;
            irq_wr_r <= 3'h0;
        end else begin
            irq_wr_r <= {irq_wr_r[1:0], irq_wr};
            if (wr_take && s_axi_awaddr == `OFS_LDO_CTL) begin
                ldo_exp <= s_axi_wdata[5:0];
            end
        end
    end
    a_ldo_follow: assert property (wr_take && s_axi_awaddr == `OFS_LDO_CTL |-> ##[1:3]
        regulator_voltage_select == ldo_exp) else $error("regulator select missed write");
    a_ldo_no_stray: assert property (regulator_voltage_select !=
        $past(regulator_voltage_select) |-> regulator_voltage_select == ldo_exp)
        else $error("regulator select changed on its own");
    a_caps_read: assert property (rd_take && s_axi_araddr == `OFS_GPIO_CAP |=>
        s_axi_rvalid && s_axi_rdata == `GPIO_CAP_VALUE) else $error("capability word wrong");
    a_src_read: assert property (rd_take && s_axi_araddr == `OFS_SRC0 |=>
        (s_axi_rdata & ~`SRC_MASK) == 32'h0000_0000) else $error("reset word stray bits");
    a_wdt_masked: assert property ($rose(wdt_soft_reset) |->
        primary_capabilities[`CAP_WDT_BIT]) else $error("absent watchdog reset");
    a_pwm_masked: assert property ($rose(pwm_soft_reset) |->
        primary_capabilities[`CAP_PWM_BIT]) else $error("absent pwm reset");
    a_reset_cause: assert property (brownout_system_reset |->
        $past(brownout_detector, 3)) else $error("reset without detector");
    a_reset_pulse: assert property (brownout_system_reset |=>
        !brownout_system_reset) else $error("reset pulse too long");
    a_route_excl: assert property (irq |-> !brownout_system_reset)
        else $error("interrupt and reset together");
    a_irq_sticky: assert property ($fell(irq) |-> irq_wr_r != 3'h0)
        else $error("interrupt dropped without write");
    c_irq: cover property ($rose(irq));
    c_bor_reset: cover property (brownout_system_reset);
    c_pwm_reset: cover property ($rose(pwm_soft_reset));
endmodule
bind brownout_ldo_softreset_ctrl brownout_ctrl_monitor brownout_ctrl_monitor_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .primary_capabilities(primary_capabilities), .brownout_detector(brownout_detector),
    .regulator_voltage_select(regulator_voltage_select),
    .brownout_system_reset(brownout_system_reset), .pwm_soft_reset(pwm_soft_reset),
    .wdt_soft_reset(wdt_soft_reset), .irq(irq));

// File: testbench/tb.sv
`timescale 1ns/10ps
`include "brownout_ctrl_regs.vh"
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic [31:0] primary_capabilities = 32'h0011_0000;
    logic        brownout_detector = 1'b0;
    logic        internal_oscillator = 1'b0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [5:0]  regulator_voltage_select;
    wire         brownout_system_reset, pwm_soft_reset, adc_soft_reset, wdt_soft_reset, irq;
    logic [5:0]  codes [0:3] = '{6'h1b, 6'h1f, 6'h00, 6'h05};
    logic        saw_irq, saw_rst, pa, pw;
    integer      bad_count = 0;
    integer      checks = 0;
    integer      i, k, n, rst_at;
    brownout_ldo_softreset_ctrl brownout_ldo_softreset_ctrl_i (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .primary_capabilities(primary_capabilities), .brownout_detector(brownout_detector),
        .internal_oscillator(internal_oscillator),
        .regulator_voltage_select(regulator_voltage_select),
        .brownout_system_reset(brownout_system_reset), .pwm_soft_reset(pwm_soft_reset),
        .adc_soft_reset(adc_soft_reset), .wdt_soft_reset(wdt_soft_reset), .irq(irq));
    always #50 aclk = ~aclk;
    // About 2.2 MHz; one rising edge in five lands exactly on a rising bus clock edge.
    always #230 internal_oscillator = ~internal_oscillator;
    task cmp(input [31:0] got, input [31:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d, input [1:0] er);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            n = 0;
            while ((pa || pw) && n < 50) begin
                @(posedge aclk);
                n = n + 1;
                if (pa && s_axi_awready === 1'b1) begin
                    pa = 1'b0;
                    s_axi_awvalid <= 1'b0;
                end
                if (pw && s_axi_wready === 1'b1) begin
                    pw = 1'b0;
                    s_axi_wvalid <= 1'b0;
                end
            end
            while (s_axi_bvalid !== 1'b1 && n < 50) begin
                @(posedge aclk);
                n = n + 1;
            end
            s_axi_bready <= 1'b0;
            if (n >= 50) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t write timed out", $time);
            end
            cmp(32'(s_axi_bresp), 32'(er));
        end
    endtask
    task rc(input [7:0] a, input [31:0] exp, input [1:0] er);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            pa = 1'b1;
            n = 0;
            while (pa && n < 50) begin
                @(posedge aclk);
                n = n + 1;
                if (s_axi_arready === 1'b1) begin
                    pa = 1'b0;
                    s_axi_arvalid <= 1'b0;
                end
            end
            while (s_axi_rvalid !== 1'b1 && n < 50) begin
                @(posedge aclk);
                n = n + 1;
            end
            s_axi_rready <= 1'b0;
            if (n >= 50) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0t read timed out", $time);
            end
            cmp(s_axi_rdata, exp);
            cmp(32'(s_axi_rresp), 32'(er));
        end
    endtask
    task watch(input integer cyc);
        begin
            saw_irq = 1'b0;
            saw_rst = 1'b0;
            rst_at = 0;
            for (k = 1; k <= cyc; k = k + 1) begin
                @(posedge aclk);
                if (irq === 1'b1) saw_irq = 1'b1;
                if (brownout_system_reset === 1'b1 && !saw_rst) begin
                    saw_rst = 1'b1;
                    rst_at = k;
                end
            end
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", checks, bad_count);
            if (bad_count == 0 && checks > 0) begin
                $display("Testbench passed");
            end else begin
                $display("Testbench failed");
            end
            $finish;
        end
    endtask
    initial begin
        #(100 * 20000);
        bad_count = bad_count + 1;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim;
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`OFS_GPIO_CAP, `GPIO_CAP_VALUE, `RESP_OKAY);
        rc(`OFS_BOR_CTL, 32'h0000_7ffd, `RESP_OKAY);
        rc(`OFS_LDO_CTL, 32'h0000_0000, `RESP_OKAY);
        rc(`OFS_SRC0, 32'h0000_0000, `RESP_OKAY);
        rc(`OFS_IRQ_STATUS, 32'h0000_0000, `RESP_OKAY);
        wr(8'h20, 32'h0000_1234, `RESP_SLVERR);
        rc(8'h20, 32'h0000_0000, `RESP_SLVERR);
        wr(`OFS_BOR_CTL, 32'h0000_fffd, `RESP_OKAY);
        rc(`OFS_BOR_CTL, 32'h0000_fffd, `RESP_OKAY);
        for (i = 0; i < 4; i = i + 1) begin
            wr(`OFS_LDO_CTL, 32'(codes[i]), `RESP_OKAY);
            rc(`OFS_LDO_CTL, 32'(codes[i]), `RESP_OKAY);
            cmp(32'(regulator_voltage_select), 32'(codes[i]));
        end
        wr(`OFS_SRC0, `SRC_MASK, `RESP_OKAY);
        rc(`OFS_SRC0, 32'h0011_0000, `RESP_OKAY);
        cmp(32'({pwm_soft_reset, adc_soft_reset, wdt_soft_reset}), 32'h0000_0006);
        primary_capabilities <= 32'h0011_0008;
        wr(`OFS_SRC0, 32'h0000_0008, `RESP_OKAY);
        rc(`OFS_SRC0, 32'h0000_0008, `RESP_OKAY);
        cmp(32'({pwm_soft_reset, adc_soft_reset, wdt_soft_reset}), 32'h0000_0001);
        wr(`OFS_SRC0, 32'h0000_0000, `RESP_OKAY);
        watch(2);
        cmp(32'({pwm_soft_reset, adc_soft_reset, wdt_soft_reset}), 32'h0000_0000);
        wr(`OFS_BOR_CTL, 32'h0000_0000, `RESP_OKAY);
        brownout_detector <= 1'b1;
        watch(30);
        brownout_detector <= 1'b0;
        cmp(32'({saw_irq, saw_rst}), 32'h0000_0000);
        rc(`OFS_IRQ_STATUS, 32'h0000_0001, `RESP_OKAY);
        wr(`OFS_IRQ_ENABLE, 32'h0000_0001, `RESP_OKAY);
        watch(2);
        cmp(32'(saw_irq), 32'h0000_0001);
        wr(`OFS_IRQ_CLEAR, 32'h0000_0001, `RESP_OKAY);
        watch(2);
        cmp(32'(irq), 32'h0000_0000);
        wr(`OFS_BOR_CTL, 32'h0000_0011, `RESP_OKAY);
        brownout_detector <= 1'b1;
        repeat (3) @(posedge aclk);
        brownout_detector <= 1'b0;
        watch(120);
        cmp(32'({saw_irq, saw_rst}), 32'h0000_0000);
        rc(`OFS_IRQ_STATUS, 32'h0000_0000, `RESP_OKAY);
        wr(`OFS_BOR_CTL, 32'h0000_0013, `RESP_OKAY);
        brownout_detector <= 1'b1;
        watch(120);
        brownout_detector <= 1'b0;
        cmp(32'({saw_irq, saw_rst}), 32'h0000_0001);
        cmp(32'(rst_at > 12), 32'h0000_0001);
        end_sim;
    end
endmodule
